// [rsc_pkg.sv]
package rsc_pkg;

  // register addresses on the serial link
  localparam logic [7:0] RSC_OFS_SLICE    = 8'h01;
  localparam logic [7:0] RSC_OFS_EMPH     = 8'h02;
  localparam logic [7:0] RSC_OFS_SWING    = 8'h03;
  localparam logic [7:0] RSC_OFS_BW0      = 8'h04;
  localparam logic [7:0] RSC_OFS_LOSS0    = 8'h08;
  localparam logic [7:0] RSC_OFS_BW_RB    = 8'h0E;
  localparam logic [7:0] RSC_OFS_LOSS_RB  = 8'h0F;
  localparam logic [7:0] RSC_UNMAPPED_VAL = 8'h00;

  // field layout and values after reset
  localparam int unsigned RSC_USE_BIT    = 7;
  localparam int unsigned RSC_BW_W       = 4;
  localparam int unsigned RSC_LOSS_W     = 7;
  localparam logic [7:0]  RSC_RESET_VAL  = 8'h00;
  localparam logic [7:0]  RSC_THR_ZERO   = 8'h80;

  // fixed defaults used while a select bit is clear
  localparam logic [3:0][13:0] RSC_BW_DEF_MHZ =
    {14'h2328, 14'h20D0, 14'h1DB0, 14'h0960};
  localparam logic [3:0][7:0] RSC_LOSS_DEF_MVPP =
    {8'h1A, 8'h1A, 8'h12, 8'h0F};
  localparam logic [3:0] RSC_BW_DEF_CODE   = 4'hF;
  localparam logic [6:0] RSC_LOSS_DEF_CODE = 7'h00;

  // output swing in mVpp
  localparam logic [9:0] RSC_SWING_LOW  = 10'h15E;
  localparam logic [9:0] RSC_SWING_MID  = 10'h28A;
  localparam logic [9:0] RSC_SWING_HIGH = 10'h352;

  typedef enum logic [3:0] {
    RSC_ST_IDLE      = 4'h0,
    RSC_ST_ADDR      = 4'h1,
    RSC_ST_ADDR_ACK  = 4'h3,
    RSC_ST_PTR       = 4'h2,
    RSC_ST_PTR_ACK   = 4'h6,
    RSC_ST_WDATA     = 4'h7,
    RSC_ST_WDATA_ACK = 4'h5,
    RSC_ST_RDATA     = 4'h4,
    RSC_ST_RDATA_ACK = 4'hC
  } rsc_state_type;

  typedef struct packed {
    logic       shift_pos;
    logic       shift_neg;
    logic [6:0] shift_mag;
    logic [3:0] emph_db;
    logic       emph_valid;
    logic [9:0] swing_mvpp;
  } rsc_codes_type;

  typedef struct packed {
    logic [1:0]  index;
    logic        use_field;
    logic [3:0]  setting;
    logic [13:0] default_mhz;
  } rsc_bw_type;

  typedef struct packed {
    logic [1:0] index;
    logic       use_field;
    logic [6:0] level;
    logic [7:0] default_mvpp;
  } rsc_loss_type;

endpackage

// [rsc_code_decode.sv]
`timescale 1ns/100ps
module rsc_code_decode
  import rsc_pkg::*;
(
  // stored codes
  input  wire logic [7:0] slice_threshold_code_i,
  input  wire logic [3:0] emphasis_code_i,
  input  wire logic [1:0] swing_code_i,
  // decoded settings
  output rsc_codes_type   codes_o
);

  always_comb begin
    codes_o = '0;
    if (slice_threshold_code_i == RSC_THR_ZERO) begin
      codes_o.shift_mag = 7'h00;
    end else if (slice_threshold_code_i < RSC_THR_ZERO) begin
      codes_o.shift_pos = 1'b1;
      codes_o.shift_mag = 7'(RSC_THR_ZERO - slice_threshold_code_i);
    end else begin
      codes_o.shift_neg = 1'b1;
      codes_o.shift_mag = 7'(slice_threshold_code_i - RSC_THR_ZERO);
    end
    // unlisted emphasis codes give 0 dB and flag the code invalid
    codes_o.emph_valid = 1'b1;
    case (emphasis_code_i)
      4'h0: codes_o.emph_db = 4'h0;
      4'h1: codes_o.emph_db = 4'h1;
      4'h3: codes_o.emph_db = 4'h2;
      4'h4: codes_o.emph_db = 4'h3;
      4'h5: codes_o.emph_db = 4'h4;
      4'h7: codes_o.emph_db = 4'h5;
      4'hC: codes_o.emph_db = 4'h6;
      4'hD: codes_o.emph_db = 4'h7;
      4'hF: codes_o.emph_db = 4'h8;
      default: begin
        codes_o.emph_db    = 4'h0;
        codes_o.emph_valid = 1'b0;
      end
    endcase
    case (swing_code_i)
      2'h0:    codes_o.swing_mvpp = RSC_SWING_LOW;
      2'h3:    codes_o.swing_mvpp = RSC_SWING_HIGH;
      default: codes_o.swing_mvpp = RSC_SWING_MID;
    endcase
  end

endmodule

// [rsc_rate_pick.sv]
`timescale 1ns/100ps
module rsc_rate_pick
  import rsc_pkg::*;
#(
  parameter int unsigned FIELD_W = 4,
  parameter int unsigned PHYS_W  = 14
)(
  // rate pins
  input  wire logic                         pin_high_i,
  input  wire logic                         pin_low_i,
  input  wire logic                         pins_open_i,
  // candidate registers
  input  wire logic [3:0]                   use_field_i,
  input  wire logic [3:0][FIELD_W-1:0]      field_i,
  input  wire logic [3:0][PHYS_W-1:0]       default_i,
  input  wire logic [FIELD_W-1:0]           default_code_i,
  // chosen register
  output logic [1:0]                        index_o,
  output logic                              use_field_o,
  output logic [FIELD_W-1:0]                setting_o,
  output logic [PHYS_W-1:0]                 default_o
);

  initial begin
    if (FIELD_W < 1 || FIELD_W > 7 || PHYS_W < 1) begin
      $error("rsc_rate_pick: unsupported widths");
    end
  end

  // floating pins fall back to the fourth register
  always_comb begin
    if (pins_open_i) begin
      index_o = 2'h3;
    end else if (!pin_high_i && !pin_low_i) begin
      index_o = 2'h0;
    end else if (!pin_high_i && pin_low_i) begin
      index_o = 2'h1;
    end else if (pin_high_i && pin_low_i) begin
      index_o = 2'h2;
    end else begin
      index_o = 2'h3;
    end
    use_field_o = use_field_i[index_o];
    default_o   = default_i[index_o];
    setting_o   = use_field_o ? field_i[index_o] : default_code_i;
  end

endmodule

// [rsc_config_bank.sv]
`timescale 1ns/100ps
module rsc_config_bank
  import rsc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary link address
)(
  // clock and reset
  input  wire logic    clock_i,
  input  wire logic    sys_rst_i,
  // two-wire serial link
  input  wire logic    scl_i,
  input  wire logic    sda_i,
  output logic         sda_o,
  output logic         sda_oe_n_o,
  // rate pins
  input  wire logic    speed_pin_high_i,
  input  wire logic    speed_pin_low_i,
  input  wire logic    speed_pins_open_i,
  // applied settings
  output rsc_codes_type codes_o,
  output rsc_bw_type    bw_o,
  output rsc_loss_type  loss_o
);

  initial begin
    if (DEV_ADDR == 7'h00 || DEV_ADDR[6:3] == 4'hF) begin
      $error("rsc_config_bank: reserved link address");
    end
  end

  // link sampling
  logic              scl_d_r;
  logic              sda_d_r;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_seen;
  logic              stop_seen;

  // link engine
  rsc_state_type     state_r;
  logic [7:0]        shift_r;
  logic [7:0]        tx_r;
  logic [2:0]        bit_cnt_r;
  logic              byte_full_r;
  logic              nack_r;
  logic [7:0]        ptr_r;
  logic              addr_match;
  logic              wr_en;
  logic [7:0]        rd_data;

  // stored registers
  logic [7:0]        slice_threshold_code_r;
  logic [3:0]        emphasis_code_r;
  logic [1:0]        swing_code_r;
  logic [3:0]        bw_use_r;
  logic [3:0][3:0]   bw_field_r;
  logic [3:0]        loss_use_r;
  logic [3:0][6:0]   loss_field_r;

  // selection results
  rsc_codes_type     codes_nxt;
  logic [1:0]        bw_index;
  logic              bw_use_sel;
  logic [3:0]        applied_bandwidth_readback;
  logic [13:0]       bw_default;
  logic [1:0]        loss_index;
  logic              loss_use_sel;
  logic [6:0]        applied_loss_level_readback;
  logic [7:0]        loss_default;

  // pins are synchronous to clock_i, so one stage gives edges
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_i;
      sda_d_r <= sda_i;
    end
  end

  // start and stop win over bit handling so a cut frame resynchronises
  assign scl_rise   = scl_i && !scl_d_r;
  assign scl_fall   = !scl_i && scl_d_r;
  assign start_seen = scl_i && scl_d_r && sda_d_r && !sda_i;
  assign stop_seen  = scl_i && scl_d_r && !sda_d_r && sda_i;
  assign addr_match = (shift_r[7:1] == DEV_ADDR);

  // a data byte commits on the falling edge after its eighth bit
  assign wr_en = (state_r == RSC_ST_WDATA) && scl_fall && byte_full_r
                 && !start_seen && !stop_seen;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r     <= RSC_ST_IDLE;
      shift_r     <= 8'h00;
      tx_r        <= 8'h00;
      bit_cnt_r   <= 3'h0;
      byte_full_r <= 1'b0;
      nack_r      <= 1'b0;
      ptr_r       <= 8'h00;
    end else if (start_seen) begin
      state_r     <= RSC_ST_ADDR;
      bit_cnt_r   <= 3'h0;
      byte_full_r <= 1'b0;
    end else if (stop_seen) begin
      state_r     <= RSC_ST_IDLE;
      byte_full_r <= 1'b0;
    end else begin
      case (state_r)
        RSC_ST_ADDR, RSC_ST_PTR, RSC_ST_WDATA: begin
          if (scl_rise) begin
            shift_r     <= {shift_r[6:0], sda_i};
            bit_cnt_r   <= bit_cnt_r + 3'h1;
            byte_full_r <= (bit_cnt_r == 3'h7);
          end else if (scl_fall && byte_full_r) begin
            byte_full_r <= 1'b0;
            if (state_r == RSC_ST_ADDR) begin
              // a foreign address leaves the bus alone until next start
              state_r <= addr_match ? RSC_ST_ADDR_ACK : RSC_ST_IDLE;
            end else if (state_r == RSC_ST_PTR) begin
              ptr_r   <= shift_r;
              state_r <= RSC_ST_PTR_ACK;
            end else begin
              ptr_r   <= ptr_r + 8'h01;
              state_r <= RSC_ST_WDATA_ACK;
            end
          end
        end
        RSC_ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 3'h0;
            if (shift_r[0]) begin
              tx_r    <= rd_data;
              ptr_r   <= ptr_r + 8'h01;
              state_r <= RSC_ST_RDATA;
            end else begin
              state_r <= RSC_ST_PTR;
            end
          end
        end
        RSC_ST_PTR_ACK, RSC_ST_WDATA_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 3'h0;
            state_r   <= RSC_ST_WDATA;
          end
        end
        RSC_ST_RDATA: begin
          if (scl_fall) begin
            tx_r      <= {tx_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              state_r <= RSC_ST_RDATA_ACK;
            end
          end
        end
        RSC_ST_RDATA_ACK: begin
          if (scl_rise) begin
            nack_r <= sda_i;
          end else if (scl_fall) begin
            bit_cnt_r <= 3'h0;
            if (nack_r) begin
              state_r <= RSC_ST_IDLE;
            end else begin
              tx_r    <= rd_data;
              ptr_r   <= ptr_r + 8'h01;
              state_r <= RSC_ST_RDATA;
            end
          end
        end
        default: begin
          state_r <= RSC_ST_IDLE;
        end
      endcase
    end
  end

  // open drain: only ever pull low, release otherwise
  assign sda_o = 1'b0;

  always_comb begin
    case (state_r)
      RSC_ST_ADDR_ACK,
      RSC_ST_PTR_ACK,
      RSC_ST_WDATA_ACK: sda_oe_n_o = 1'b0;
      RSC_ST_RDATA:     sda_oe_n_o = tx_r[7];
      default:          sda_oe_n_o = 1'b1;
    endcase
  end

  // writes keep only defined bits; readback and unmapped are ignored
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slice_threshold_code_r <= RSC_RESET_VAL;
      emphasis_code_r        <= RSC_RESET_VAL[3:0];
      swing_code_r           <= RSC_RESET_VAL[1:0];
    end else if (wr_en) begin
      if (ptr_r == RSC_OFS_SLICE) begin
        slice_threshold_code_r <= shift_r;
      end else if (ptr_r == RSC_OFS_EMPH) begin
        emphasis_code_r <= shift_r[3:0];
      end else if (ptr_r == RSC_OFS_SWING) begin
        swing_code_r <= shift_r[1:0];
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_sel_regs
    localparam logic [7:0] BW_OFS   = RSC_OFS_BW0 + 8'(g);
    localparam logic [7:0] LOSS_OFS = RSC_OFS_LOSS0 + 8'(g);
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        bw_use_r[g]     <= RSC_RESET_VAL[RSC_USE_BIT];
        bw_field_r[g]   <= RSC_RESET_VAL[RSC_BW_W-1:0];
        loss_use_r[g]   <= RSC_RESET_VAL[RSC_USE_BIT];
        loss_field_r[g] <= RSC_RESET_VAL[RSC_LOSS_W-1:0];
      end else if (wr_en && ptr_r == BW_OFS) begin
        bw_use_r[g]   <= shift_r[RSC_USE_BIT];
        bw_field_r[g] <= shift_r[RSC_BW_W-1:0];
      end else if (wr_en && ptr_r == LOSS_OFS) begin
        loss_use_r[g]   <= shift_r[RSC_USE_BIT];
        loss_field_r[g] <= shift_r[RSC_LOSS_W-1:0];
      end
    end
  end

  // read mux, addressed by the auto-incrementing pointer
  always_comb begin
    if (ptr_r == RSC_OFS_SLICE) begin
      rd_data = slice_threshold_code_r;
    end else if (ptr_r == RSC_OFS_EMPH) begin
      rd_data = {4'h0, emphasis_code_r};
    end else if (ptr_r == RSC_OFS_SWING) begin
      rd_data = {6'h00, swing_code_r};
    end else if (ptr_r >= RSC_OFS_BW0 && ptr_r < RSC_OFS_LOSS0) begin
      rd_data = {bw_use_r[ptr_r[1:0]], 3'h0, bw_field_r[ptr_r[1:0]]};
    end else if (ptr_r >= RSC_OFS_LOSS0
                 && ptr_r < RSC_OFS_LOSS0 + 8'h04) begin
      rd_data = {loss_use_r[ptr_r[1:0]], loss_field_r[ptr_r[1:0]]};
    end else if (ptr_r == RSC_OFS_BW_RB) begin
      rd_data = {4'h0, applied_bandwidth_readback};
    end else if (ptr_r == RSC_OFS_LOSS_RB) begin
      rd_data = {1'b0, applied_loss_level_readback};
    end else begin
      rd_data = RSC_UNMAPPED_VAL;
    end
  end

  rsc_code_decode u_decode (
    .slice_threshold_code_i (slice_threshold_code_r),
    .emphasis_code_i        (emphasis_code_r),
    .swing_code_i           (swing_code_r),
    .codes_o                (codes_nxt)
  );

  // bandwidth register chosen by the rate pins
  rsc_rate_pick #(
    .FIELD_W (RSC_BW_W),
    .PHYS_W  (14)
  ) u_bw_pick (
    .pin_high_i     (speed_pin_high_i),
    .pin_low_i      (speed_pin_low_i),
    .pins_open_i    (speed_pins_open_i),
    .use_field_i    (bw_use_r),
    .field_i        (bw_field_r),
    .default_i      (RSC_BW_DEF_MHZ),
    .default_code_i (RSC_BW_DEF_CODE),
    .index_o        (bw_index),
    .use_field_o    (bw_use_sel),
    .setting_o      (applied_bandwidth_readback),
    .default_o      (bw_default)
  );

  // loss register follows the same pin decode
  // floating pins pick the same slot here as for bandwidth, on purpose
  rsc_rate_pick #(
    .FIELD_W (RSC_LOSS_W),
    .PHYS_W  (8)
  ) u_loss_pick (
    .pin_high_i     (speed_pin_high_i),
    .pin_low_i      (speed_pin_low_i),
    .pins_open_i    (speed_pins_open_i),
    .use_field_i    (loss_use_r),
    .field_i        (loss_field_r),
    .default_i      (RSC_LOSS_DEF_MVPP),
    .default_code_i (RSC_LOSS_DEF_CODE),
    .index_o        (loss_index),
    .use_field_o    (loss_use_sel),
    .setting_o      (applied_loss_level_readback),
    .default_o      (loss_default)
  );

  // settings to the analogue side change one clock after the cause
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      codes_o <= '0;
    end else begin
      codes_o <= codes_nxt;
    end
  end

  // the pins may move at any time, so the choice is taken every clock
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bw_o <= '0;
    end else begin
      bw_o.index       <= bw_index;
      bw_o.use_field   <= bw_use_sel;
      bw_o.setting     <= applied_bandwidth_readback;
      bw_o.default_mhz <= bw_default;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      loss_o <= '0;
    end else begin
      loss_o.index        <= loss_index;
      loss_o.use_field    <= loss_use_sel;
      loss_o.level        <= applied_loss_level_readback;
      loss_o.default_mvpp <= loss_default;
    end
  end

endmodule

// [rsc_config_bank_assertions.sv]
`timescale 1ns/100ps
module rsc_config_bank_assertions
  import rsc_pkg::*;
(
  // clock and reset
  input  wire logic          clock_i,
  input  wire logic          sys_rst_i,
  // serial link
  input  wire logic          scl_i,
  input  wire logic          sda_i,
  input  wire logic          sda_o,
  input  wire logic          sda_oe_n_o,
  // rate pins
  input  wire logic          speed_pin_high_i,
  input  wire logic          speed_pin_low_i,
  input  wire logic          speed_pins_open_i,
  // applied settings
  input  wire rsc_codes_type codes_o,
  input  wire rsc_bw_type    bw_o,
  input  wire rsc_loss_type  loss_o
);
  logic [1:0]  pin_idx;
  logic [13:0] want_mhz;
  logic [7:0]  want_mvpp;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // floating pins override whatever the pin inputs read
  assign pin_idx = speed_pins_open_i ? 2'h3 :
                   {speed_pin_high_i, speed_pin_high_i ^ speed_pin_low_i};
  assign want_mhz = bw_o.index[1] ?
                    (bw_o.index[0] ? 14'h2328 : 14'h20D0) :
                    (bw_o.index[0] ? 14'h1DB0 : 14'h0960);
  assign want_mvpp = loss_o.index[1] ? 8'h1A :
                     (loss_o.index[0] ? 8'h12 : 8'h0F);

  chk_bw_pick: assert property (
    $stable(pin_idx) [*3] |-> bw_o.index == pin_idx)
    else $error("bandwidth choice does not follow rate pins");
  chk_loss_pick: assert property (
    $stable(pin_idx) [*3] |-> loss_o.index == pin_idx)
    else $error("loss level choice does not follow rate pins");
  chk_bw_default: assert property (
    !$past(sys_rst_i) && !bw_o.use_field
    |-> bw_o.setting == 4'hF && bw_o.default_mhz == want_mhz)
    else $error("bandwidth default wrong");
  chk_loss_default: assert property (
    !$past(sys_rst_i) && !loss_o.use_field
    |-> loss_o.level == 7'h00 && loss_o.default_mvpp == want_mvpp)
    else $error("loss level default wrong");
  chk_shift_excl: assert property (
    !(codes_o.shift_pos && codes_o.shift_neg)
    && (codes_o.shift_pos || codes_o.shift_neg
        || codes_o.shift_mag == 7'h00))
    else $error("threshold shift sign wrong");
  chk_neg_mag: assert property (
    codes_o.shift_neg |-> codes_o.shift_mag != 7'h00)
    else $error("negative shift without size");
  chk_swing_set: assert property (
    !$past(sys_rst_i)
    |-> codes_o.swing_mvpp inside {10'h15E, 10'h28A, 10'h352})
    else $error("output swing out of set");
  chk_emph_range: assert property (
    !$past(sys_rst_i)
    |-> codes_o.emph_db <= (codes_o.emph_valid ? 4'h8 : 4'h0))
    else $error("emphasis level out of range");
  // a pull that began while scl was high would read as a start or stop
  chk_ack_hold: assert property (
    $fell(sda_oe_n_o) |-> !scl_i ##1 !sda_oe_n_o [*4])
    else $error("data pull started at wrong time or too short");

  cover property (bw_o.use_field && bw_o.index == 2'h3);
  cover property (loss_o.use_field && loss_o.level == 7'h7F);
  cover property (codes_o.shift_neg && codes_o.shift_mag == 7'h7F);
endmodule

bind rsc_config_bank rsc_config_bank_assertions chk (.*);

// [rsc_link_host.sv]
`timescale 1ns/100ps
module rsc_link_host (
  // clock
  input  wire logic clock_i,
  // resolved data line
  input  wire logic sda_i,
  // line drive
  output logic      scl_o,
  output logic      sda_low_o
);
  // extra low-phase clocks; raised by the bench for a slow host
  int stretch = 2;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // data moves two clocks into the low phase, clear of both edges
  task automatic put_bit(input logic b);
    scl_o <= 1'b0;
    tick(2);
    sda_low_o <= !b;
    tick(stretch);
    scl_o <= 1'b1;
    tick(4);
  endtask

  task automatic get_bit(output logic b);
    scl_o <= 1'b0;
    sda_low_o <= 1'b0;
    tick(2 + stretch);
    scl_o <= 1'b1;
    tick(2);
    b = sda_i;
    tick(2);
  endtask

  task automatic put_byte(input logic [7:0] v, output logic nak);
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(nak);
  endtask

  task automatic start(input logic again);
    if (again) begin
      scl_o <= 1'b0;
      tick(4);
      scl_o <= 1'b1;
      tick(4);
    end
    sda_low_o <= 1'b1;
    tick(4);
  endtask

  task automatic stop;
    scl_o <= 1'b0;
    tick(2);
    sda_low_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b0;
    tick(4);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] p, d,
                    output logic [2:0] n);
    start(1'b0);
    put_byte({a, 1'b0}, n[2]);
    put_byte(p, n[1]);
    put_byte(d, n[0]);
    stop();
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] p,
                    output logic [7:0] d, output logic [2:0] n);
    start(1'b0);
    put_byte({a, 1'b0}, n[2]);
    put_byte(p, n[1]);
    start(1'b1);
    put_byte({a, 1'b1}, n[0]);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop();
  endtask
endmodule

// [rsc_config_bank_tb.sv]
`timescale 1ns/100ps
module rsc_config_bank_tb;
  import rsc_pkg::*;
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [13:0] MHZ [4] = '{14'h0960, 14'h1DB0, 14'h20D0, 14'h2328};
  localparam logic [7:0] MV [4] = '{8'h0F, 8'h12, 8'h1A, 8'h1A};
  localparam logic [6:0] LV [4] = '{7'h00, 7'h2A, 7'h55, 7'h7F};
  localparam logic [2:0] PIN [6] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h4, 3'h7};
  localparam logic [1:0] IDX [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
  localparam logic [7:0] THR [5] = '{8'h01, 8'h7F, 8'h80, 8'h81, 8'hFF};
  localparam logic [9:0] SW [4] = '{10'h15E, 10'h28A, 10'h28A, 10'h352};
  localparam logic [4:0] EMPH [16] = '{5'h10, 5'h11, 5'h00, 5'h12, 5'h13,
    5'h14, 5'h00, 5'h15, 5'h00, 5'h00, 5'h00, 5'h00, 5'h16, 5'h17, 5'h00,
    5'h18};
  logic          clock_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  logic          pin_hi = 1'b0;
  logic          pin_lo = 1'b0;
  logic          pin_open = 1'b0;
  logic          scl, host_low, sda_oe_n, sda_out, sda;
  rsc_codes_type codes;
  rsc_bw_type    bw;
  rsc_loss_type  loss;
  logic [7:0]    rdata, m;
  logic [2:0]    nak;
  int            fails = 0;
  int            check_count = 0;

  always #20 clock_i = ~clock_i;
  // open-drain line with a pull-up
  assign sda = host_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);

  rsc_config_bank uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_out), .sda_oe_n_o(sda_oe_n),
    .speed_pin_high_i(pin_hi), .speed_pin_low_i(pin_lo),
    .speed_pins_open_i(pin_open), .codes_o(codes), .bw_o(bw),
    .loss_o(loss));
  rsc_link_host host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(host_low));

  task automatic chk(input logic [23:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] p, d);
    host.wr(ADDR, p, d, nak);
    chk(24'(nak), 24'h0, "write ack");
  endtask

  task automatic rd(input logic [7:0] p, e);
    host.rd(ADDR, p, rdata, nak);
    chk(24'({nak, rdata}), 24'(e), "read");
  endtask

  task automatic pins_chk(input int k, input logic prog);
    logic [1:0] i;
    logic [3:0] s;
    logic [6:0] l;
    i = IDX[k];
    s = prog ? 4'h5 + 4'(i) : 4'hF;
    l = prog ? LV[i] : 7'h00;
    @(posedge clock_i);
    {pin_open, pin_hi, pin_lo} <= PIN[k];
    repeat (3) @(posedge clock_i);
    chk(24'(bw), 24'({i, prog, s, MHZ[i]}), "bw");
    chk(24'(loss), 24'({i, prog, l, MV[i]}), "loss");
    rd(RSC_OFS_BW_RB, {4'h0, s});
    rd(RSC_OFS_LOSS_RB, {1'b0, l});
  endtask

  task automatic conclude;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock_i);
    fails++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rd(RSC_OFS_SLICE, 8'h00);
    chk(24'(codes.swing_mvpp), 24'(SW[0]), "reset swing");
    foreach (THR[k]) begin
      wr(RSC_OFS_SLICE, THR[k]);
      m = THR[k] < 8'h80 ? 8'h80 - THR[k] : THR[k] - 8'h80;
      m[7] = THR[k] > 8'h80;
      chk(24'(codes[23:15]), 24'({THR[k] < 8'h80, m}), "shift");
    end
    for (int c = 0; c < 16; c++) begin
      wr(RSC_OFS_EMPH, 8'(c));
      chk(24'({codes.emph_valid, codes.emph_db}), 24'(EMPH[c]), "emph");
    end
    // slow host: long low phases must not upset bit timing
    host.stretch = 6;
    for (int c = 0; c < 4; c++) begin
      wr(RSC_OFS_SWING, 8'(c));
      chk(24'(codes.swing_mvpp), 24'(SW[c]), "swing");
    end
    host.stretch = 2;
    for (int k = 0; k < 6; k++) pins_chk(k, 1'b0);
    for (int j = 0; j < 4; j++) begin
      wr(RSC_OFS_BW0 + 8'(j), 8'h85 + 8'(j));
      wr(RSC_OFS_LOSS0 + 8'(j), {1'b1, LV[j]});
    end
    for (int k = 0; k < 6; k++) pins_chk(k, 1'b1);
    wr(RSC_OFS_BW0 + 8'h03, 8'h7A);
    rd(RSC_OFS_BW0 + 8'h03, 8'h0A);
    rd(RSC_OFS_BW_RB, 8'h0F);
    wr(RSC_OFS_LOSS_RB, 8'h55);
    rd(RSC_OFS_LOSS_RB, 8'h7F);
    rd(8'h20, 8'h00);
    host.wr(ADDR ^ 7'h01, RSC_OFS_SWING, 8'h00, nak);
    chk(24'(nak[2]), 24'h1, "foreign ack");
    chk(24'(codes.swing_mvpp), 24'(SW[3]), "swing kept");
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rd(RSC_OFS_BW0, 8'h00);
    pins_chk(3, 1'b0);
    conclude();
  end
endmodule
